// >>> pkg/cafe_regs.svh
`ifndef CAFE_REGS_SVH
`define CAFE_REGS_SVH
// register byte offsets
`define CAFE_CTRL_OFF      12'h000
`define CAFE_RANGE_OFF     12'h004
`define CAFE_EXC_OFF       12'h008
`define CAFE_OFFS_OFF      12'h00C
`define CAFE_STBY_OFF      12'h010
`define CAFE_PWR_OFF       12'h014
`define CAFE_WAKE_OFF      12'h018
`define CAFE_THR_OFF       12'h01C
`define CAFE_RES1_OFF      12'h020
`define CAFE_RES2_OFF      12'h024
`define CAFE_STAT_OFF      12'h028
// control fields
`define CAFE_CTRL_SINGLE_CONV_ENABLE     0
`define CAFE_CTRL_SCT      1
`define CAFE_CTRL_SB       2
// range codes and reset values
`define CAFE_RNG_20PF      2'h0
`define CAFE_RNG_10PF      2'h1
`define CAFE_RNG_5PF       2'h2
`define CAFE_OFFS_MAX      6'h3F
`define CAFE_FREQ_MIN_KHZ  100
`define CAFE_FREQ_MAX_KHZ  500
`define CAFE_FREQ_STEP_KHZ 10
`define CAFE_FREQ_CODE_MAX 6'h28
`define CAFE_DIV_RST       5'h01
`define CAFE_PD_BOTH       2'h3
// timing: max conversion rate 1.66 kHz at 100 MHz pclk
`define CAFE_CONV_HZ_X100  166000
`define CAFE_CLK_HZ        100000000
`define CAFE_CONV_CYC      ((`CAFE_CLK_HZ * 100 + `CAFE_CONV_HZ_X100 - 1) \
                           / `CAFE_CONV_HZ_X100)
`endif

// >>> pkg/cafe_pkg.sv
package cafe_pkg;
   typedef enum logic [1:0] {CAFE_IDLE, CAFE_CONV, CAFE_DONE} cafe_state_e;
   typedef logic [11:0] cafe_res_t;
endpackage : cafe_pkg

// >>> design/cafe_ctrl.sv
// Function
// - each channel delivers 12-bit result words
// - range offers 20, 10, 5 pF
// - offset programmable 1pF steps to 63pF
// - excitation 100 to 500 kHz, 10kHz steps
// - guards follow channel power-down, not the excitation
// - conversions no faster than 1.66kHz
// - spread sweeps low bound plus bandwidth
// - standby stops cpu, converts at reduced rate
// - discriminator wakes device from standby
// - watchdog resets processor when unserviced
// - control registers rw, status results read-only
// - ranges independent, reset to 20pF
// - separate offset register per channel
// - single-conversion enable bit selects mode
// - trigger bit self-clears after conversion
// - single mode powers frontend during conversion
// - standby bit enters standby, uses dividers
// - one standby bit serves both channels
// - frontend power-down leaves processor running
// - standby rates max/D and max/(D*S)
// - both channels down resets frontend state
// - wake combine and/or, upper 8 bits, enables
// - data-ready set per result, overwrite allowed
`timescale 1ns/1ns
`include "cafe_regs.svh"
module cafe_ctrl #(
   parameter int CONV_CYC = `CAFE_CONV_CYC
) (
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [11:0]        paddr,
   input  wire logic [31:0]        pwdata,
   output logic      [31:0]        prdata,
   output logic                    pready,
   output logic                    pslverr,
   input  wire cafe_pkg::cafe_res_t adc_result_ch1,
   input  wire cafe_pkg::cafe_res_t adc_result_ch2,
   input  wire logic               wdt_kick,
   output logic                    cpu_stop,
   output logic                    cpu_reset,
   output logic                    exc_enable,
   output logic      [5:0]         exc_freq_code,
   output logic                    guard_out_ch1,
   output logic                    guard_out_ch2,
   output logic                    conv_strobe_ch1,
   output logic                    conv_strobe_ch2,
   output logic      [1:0]         range_select_ch1,
   output logic      [1:0]         range_select_ch2,
   output logic      [5:0]         offset_comp_ch1,
   output logic      [5:0]         offset_comp_ch2
);
   import cafe_pkg::*;

   localparam int          WDT_CYC = 65536;
   localparam logic [31:0] CONV_W  = 32'(CONV_CYC);

   // register state
   logic        single_conv_enable_q, single_conv_trigger_q;
   logic        standby_control_q;
   logic [1:0]  rng1_q, rng2_q, afe_power_down_q;
   logic [5:0]  excitation_low_bound_q, spread_bandwidth_q;
   logic [5:0]  offs1_q, offs2_q;
   logic [4:0]  standby_rate_divider_q, ch2_standby_subdivider_q;
   logic [5:0]  wake_criteria_q;  // per ch: combine, abs en, slope en
   logic [7:0]  abs_thr1_q, abs_thr2_q, slope_thr1_q, slope_thr2_q;
   cafe_res_t   res1_q, res2_q;
   logic [7:0]  prev1_q, prev2_q;
   logic        data_ready_ch1_q, data_ready_ch2_q;
   logic        wake1_q, wake2_q;
   logic [31:0] rate_cnt_q;
   logic [4:0]  div_cnt_q, sub_cnt_q;
   logic [5:0]  sweep_q;
   logic [16:0] wdt_q;
   cafe_state_e state_q;

   // apb decode
   wire wr_en = psel & penable & pwrite;
   wire rd_en = psel & penable & ~pwrite;
   function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
      hit = (a == o);
   endfunction : hit
   wire w_ctrl  = wr_en & hit(paddr, `CAFE_CTRL_OFF);
   wire w_range = wr_en & hit(paddr, `CAFE_RANGE_OFF);
   wire w_exc   = wr_en & hit(paddr, `CAFE_EXC_OFF);
   wire w_offs  = wr_en & hit(paddr, `CAFE_OFFS_OFF);
   wire w_stby  = wr_en & hit(paddr, `CAFE_STBY_OFF);
   wire w_pwr   = wr_en & hit(paddr, `CAFE_PWR_OFF);
   wire w_wake  = wr_en & hit(paddr, `CAFE_WAKE_OFF);
   wire w_thr   = wr_en & hit(paddr, `CAFE_THR_OFF);
   wire r_res1  = rd_en & hit(paddr, `CAFE_RES1_OFF);
   wire r_res2  = rd_en & hit(paddr, `CAFE_RES2_OFF);
   wire known   = hit(paddr, `CAFE_CTRL_OFF) | hit(paddr, `CAFE_RANGE_OFF) |
                  hit(paddr, `CAFE_EXC_OFF) | hit(paddr, `CAFE_OFFS_OFF) |
                  hit(paddr, `CAFE_STBY_OFF) | hit(paddr, `CAFE_PWR_OFF) |
                  hit(paddr, `CAFE_WAKE_OFF) | hit(paddr, `CAFE_THR_OFF) |
                  hit(paddr, `CAFE_RES1_OFF) | hit(paddr, `CAFE_RES2_OFF) |
                  hit(paddr, `CAFE_STAT_OFF);
   // writes to read-only registers are refused with an error
   wire ro_addr = hit(paddr, `CAFE_RES1_OFF) | hit(paddr, `CAFE_RES2_OFF) |
                  hit(paddr, `CAFE_STAT_OFF);
   wire bad     = ~known | (pwrite & ro_addr);

   // read mux
   logic [31:0] rd_mux;
   assign rd_mux =
      hit(paddr, `CAFE_CTRL_OFF) ? {29'h0, standby_control_q,
         single_conv_trigger_q, single_conv_enable_q} :
      hit(paddr, `CAFE_RANGE_OFF) ? {28'h0, rng2_q, rng1_q} :
      hit(paddr, `CAFE_EXC_OFF) ? {20'h0, spread_bandwidth_q,
         excitation_low_bound_q} :
      hit(paddr, `CAFE_OFFS_OFF) ? {20'h0, offs2_q, offs1_q} :
      hit(paddr, `CAFE_STBY_OFF) ? {22'h0, ch2_standby_subdivider_q,
         standby_rate_divider_q} :
      hit(paddr, `CAFE_PWR_OFF) ? {30'h0, afe_power_down_q} :
      hit(paddr, `CAFE_WAKE_OFF) ? {26'h0, wake_criteria_q} :
      hit(paddr, `CAFE_THR_OFF) ? {slope_thr2_q, slope_thr1_q,
         abs_thr2_q, abs_thr1_q} :
      hit(paddr, `CAFE_RES1_OFF) ? {20'h0, res1_q} :
      hit(paddr, `CAFE_RES2_OFF) ? {20'h0, res2_q} :
      hit(paddr, `CAFE_STAT_OFF) ? {28'h0, wake2_q, wake1_q,
         data_ready_ch2_q, data_ready_ch1_q} : 32'h0000_0000;

   // frontend conditions
   wire all_down = (afe_power_down_q == `CAFE_PD_BOTH);
   wire ch1_on   = ~afe_power_down_q[0];
   wire ch2_on   = ~afe_power_down_q[1];
   wire rate_hit = (rate_cnt_q >= CONV_W - 32'h0000_0001);
   // standby divides channel 1 by D and channel 2 by D*S
   wire [4:0] d_lim = (standby_rate_divider_q == 5'h00) ? 5'h00 :
                      standby_rate_divider_q - 5'h01;
   wire [4:0] s_lim = (ch2_standby_subdivider_q == 5'h00) ? 5'h00 :
                      ch2_standby_subdivider_q - 5'h01;
   wire d_tick = rate_hit & (~standby_control_q | div_cnt_q >= d_lim);
   wire s_tick = ~standby_control_q | sub_cnt_q >= s_lim;
   wire single_go = (state_q == CAFE_DONE);
   wire conv_ev  = single_conv_enable_q ? single_go : d_tick;
   wire ev1 = conv_ev & ch1_on & ~all_down;
   wire ev2 = conv_ev & s_tick & ch2_on & ~all_down;
   wire [6:0] f_sum = {1'b0, excitation_low_bound_q} + {1'b0, sweep_q};
   wire       f_over = f_sum > {1'b0, `CAFE_FREQ_CODE_MAX};  // no wrap

   // wake discriminator on upper 8 result bits
   wire [7:0] up1 = adc_result_ch1[11:4];
   wire [7:0] up2 = adc_result_ch2[11:4];
   wire [7:0] dl1 = (up1 > prev1_q) ? up1 - prev1_q : prev1_q - up1;
   wire [7:0] dl2 = (up2 > prev2_q) ? up2 - prev2_q : prev2_q - up2;
   wire a1 = wake_criteria_q[1] & (up1 > abs_thr1_q);
   wire r1 = wake_criteria_q[2] & (dl1 > slope_thr1_q);
   wire a2 = wake_criteria_q[4] & (up2 > abs_thr2_q);
   wire r2 = wake_criteria_q[5] & (dl2 > slope_thr2_q);
   wire wk1 = ev1 & (wake_criteria_q[0] ? (a1 & r1) : (a1 | r1));
   wire wk2 = ev2 & (wake_criteria_q[3] ? (a2 & r2) : (a2 | r2));
   wire wake_hit = standby_control_q & (wk1 | wk2);

   // apb response, single-cycle access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & bad;
         prdata  <= rd_mux;
      end
   end

   // control registers, reset ranges to 20pF
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rng1_q <= `CAFE_RNG_20PF;
         rng2_q <= `CAFE_RNG_20PF;
         excitation_low_bound_q <= 6'h00;
         spread_bandwidth_q <= 6'h00;
         offs1_q <= 6'h00;
         offs2_q <= 6'h00;
         standby_rate_divider_q <= `CAFE_DIV_RST;
         ch2_standby_subdivider_q <= `CAFE_DIV_RST;
         afe_power_down_q <= 2'h0;
         wake_criteria_q <= 6'h00;
         {slope_thr2_q, slope_thr1_q, abs_thr2_q, abs_thr1_q} <= 32'h0;
         single_conv_enable_q <= 1'b0;
      end else begin
         if (w_range && pwdata[1:0] != 2'h3 && pwdata[3:2] != 2'h3) begin
            rng1_q <= pwdata[1:0];
            rng2_q <= pwdata[3:2];
         end
         if (w_exc) begin
            excitation_low_bound_q <= pwdata[5:0];
            spread_bandwidth_q <= pwdata[11:6];
         end
         if (w_offs) begin
            offs1_q <= pwdata[5:0];
            offs2_q <= pwdata[11:6];
         end
         if (w_stby) begin
            standby_rate_divider_q <= pwdata[4:0];
            ch2_standby_subdivider_q <= pwdata[9:5];
         end
         if (w_pwr)
            afe_power_down_q <= pwdata[1:0];
         if (w_wake)
            wake_criteria_q <= pwdata[5:0];
         if (w_thr)
            {slope_thr2_q, slope_thr1_q, abs_thr2_q, abs_thr1_q} <= pwdata;
         if (w_ctrl)
            single_conv_enable_q <= pwdata[`CAFE_CTRL_SINGLE_CONV_ENABLE];
      end
   end

   // shared standby bit; wake clears it and wins over a write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         standby_control_q <= 1'b0;
      else if (wake_hit)
         standby_control_q <= 1'b0;
      else if (w_ctrl)
         standby_control_q <= pwdata[`CAFE_CTRL_SB];
   end

   // single-conversion sequencer; trigger self-clears when done
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= CAFE_IDLE;
         single_conv_trigger_q <= 1'b0;
      end else begin
         case (state_q)
            CAFE_IDLE: begin
               if (w_ctrl && pwdata[`CAFE_CTRL_SCT] && pwdata[`CAFE_CTRL_SINGLE_CONV_ENABLE])
               begin
                  single_conv_trigger_q <= 1'b1;
                  state_q <= CAFE_CONV;
               end
            end
            CAFE_CONV: begin
               if (rate_hit)
                  state_q <= CAFE_DONE;
            end
            default: begin
               single_conv_trigger_q <= 1'b0;
               state_q <= CAFE_IDLE;
            end
         endcase
      end
   end

   // conversion pacing counters; power-down of both resets them
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rate_cnt_q <= 32'h0000_0000;
         div_cnt_q  <= 5'h00;
         sub_cnt_q  <= 5'h00;
      end else if (all_down || (single_conv_enable_q && state_q == CAFE_IDLE))
      begin
         rate_cnt_q <= 32'h0000_0000;
         div_cnt_q  <= 5'h00;
         sub_cnt_q  <= 5'h00;
      end else if (rate_hit) begin
         rate_cnt_q <= 32'h0000_0000;
         if (d_tick) begin
            div_cnt_q <= 5'h00;
            sub_cnt_q <= s_tick ? 5'h00 : sub_cnt_q + 5'h01;
         end else
            div_cnt_q <= div_cnt_q + 5'h01;
      end else
         rate_cnt_q <= rate_cnt_q + 32'h0000_0001;
   end

   // result capture, data-ready and wake flags; set beats read clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         res1_q <= 12'h000;
         res2_q <= 12'h000;
         prev1_q <= 8'h00;
         prev2_q <= 8'h00;
         data_ready_ch1_q <= 1'b0;
         data_ready_ch2_q <= 1'b0;
         wake1_q <= 1'b0;
         wake2_q <= 1'b0;
      end else if (all_down) begin
         res1_q <= 12'h000;
         res2_q <= 12'h000;
         prev1_q <= 8'h00;
         prev2_q <= 8'h00;
         data_ready_ch1_q <= 1'b0;
         data_ready_ch2_q <= 1'b0;
         wake1_q <= 1'b0;
         wake2_q <= 1'b0;
      end else begin
         if (ev1) begin
            res1_q <= adc_result_ch1;
            prev1_q <= up1;
         end
         if (ev2) begin
            res2_q <= adc_result_ch2;
            prev2_q <= up2;
         end
         data_ready_ch1_q <= ev1 | (data_ready_ch1_q & ~r_res1);
         data_ready_ch2_q <= ev2 | (data_ready_ch2_q & ~r_res2);
         wake1_q <= (standby_control_q & wk1) | wake1_q;
         wake2_q <= (standby_control_q & wk2) | wake2_q;
      end
   end

   // watchdog: processor reset when software stops kicking
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         wdt_q <= 17'h0_0000;
      else if (wdt_kick || wdt_q[16])
         wdt_q <= 17'h0_0000;
      else
         wdt_q <= wdt_q + 17'h0_0001;
   end

   // registered outputs toward analog and processor
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cpu_stop <= 1'b0;
         cpu_reset <= 1'b0;
         exc_enable <= 1'b0;
         exc_freq_code <= 6'h00;
         guard_out_ch1 <= 1'b0;
         guard_out_ch2 <= 1'b0;
         conv_strobe_ch1 <= 1'b0;
         conv_strobe_ch2 <= 1'b0;
         range_select_ch1 <= `CAFE_RNG_20PF;
         range_select_ch2 <= `CAFE_RNG_20PF;
         offset_comp_ch1 <= 6'h00;
         offset_comp_ch2 <= 6'h00;
         sweep_q <= 6'h00;
      end else begin
         cpu_stop <= standby_control_q & ~wake_hit;
         cpu_reset <= (wdt_q == 17'(WDT_CYC)) & ~wdt_kick;
         exc_enable <= ~all_down & (~single_conv_enable_q |
                       state_q != CAFE_IDLE);
         sweep_q <= (sweep_q >= spread_bandwidth_q) ? 6'h00 :
                    sweep_q + 6'h01;
         exc_freq_code <= f_over ? `CAFE_FREQ_CODE_MAX : f_sum[5:0];
         guard_out_ch1 <= ~all_down & ch1_on;
         guard_out_ch2 <= ~all_down & ch2_on;
         conv_strobe_ch1 <= ev1;
         conv_strobe_ch2 <= ev2;
         range_select_ch1 <= rng1_q;
         range_select_ch2 <= rng2_q;
         offset_comp_ch1 <= offs1_q;
         offset_comp_ch2 <= offs2_q;
      end
   end

   // checks
   property p_ready_one;
      @(posedge pclk) disable iff (!presetn)
      (psel && !penable) |=> pready ##1 !pready;
   endproperty
   a_ready_one: assert property (p_ready_one) else $error("pready");
   property p_sct_clear;
      @(posedge pclk) disable iff (!presetn)
      (state_q == CAFE_DONE) |=> !single_conv_trigger_q;
   endproperty
   a_sct_clear: assert property (p_sct_clear) else $error("sct");
   property p_wake_sb;
      @(posedge pclk) disable iff (!presetn)
      wake_hit |=> !standby_control_q ##1 !cpu_stop;
   endproperty
   a_wake_sb: assert property (p_wake_sb) else $error("wake");
   property p_down_clear;
      @(posedge pclk) disable iff (!presetn)
      all_down |=> !data_ready_ch1_q && !data_ready_ch2_q;
   endproperty
   a_down_clear: assert property (p_down_clear) else $error("pd");
   property p_dr_set;
      @(posedge pclk) disable iff (!presetn)
      ev1 |=> data_ready_ch1_q && res1_q == $past(adc_result_ch1);
   endproperty
   a_dr_set: assert property (p_dr_set) else $error("dr");
   property p_rate;
      @(posedge pclk) disable iff (!presetn)
      conv_strobe_ch1 |=> !conv_strobe_ch1 [*8];
   endproperty
   a_rate: assert property (p_rate) else $error("rate");
   property p_rng;
      @(posedge pclk) disable iff (!presetn)
      range_select_ch1 != 2'h3 && range_select_ch2 != 2'h3;
   endproperty
   a_rng: assert property (p_rng) else $error("range");
   property p_freq;
      @(posedge pclk) disable iff (!presetn)
      exc_freq_code <= `CAFE_FREQ_CODE_MAX;
   endproperty
   a_freq: assert property (p_freq) else $error("freq");
   c_single: cover property (@(posedge pclk) state_q == CAFE_DONE);
   c_wake: cover property (@(posedge pclk) wake_hit);
   c_conv2: cover property (@(posedge pclk) conv_strobe_ch2);
endmodule : cafe_ctrl

// >>> verification/cafe_conv_model.sv
`timescale 1ns/1ns
module cafe_conv_model (
   input  wire logic                pclk,
   input  wire logic                presetn,
   input  wire logic                exc_enable,
   input  wire cafe_pkg::cafe_res_t level_ch1,
   input  wire cafe_pkg::cafe_res_t level_ch2,
   output cafe_pkg::cafe_res_t      adc_result_ch1,
   output cafe_pkg::cafe_res_t      adc_result_ch2
);
   import cafe_pkg::*;
   logic flip_q;
   // pattern source for an unpowered converter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flip_q <= 1'b0;
      end else begin
         flip_q <= ~flip_q;
      end
   end
   // unpowered outputs toggle so a stale sample never looks valid
   assign adc_result_ch1 = exc_enable ? level_ch1 : {12{flip_q}};
   assign adc_result_ch2 = exc_enable ? level_ch2 : {12{flip_q}};
endmodule : cafe_conv_model

// >>> verification/capacitive_afe_conversion_control_tb_top.sv
`timescale 1ns/1ns
`include "cafe_regs.svh"
module capacitive_afe_conversion_control_tb_top;
   import cafe_pkg::*;
   localparam int CC = 20;
   logic        pclk, presetn, psel, penable, pwrite, wdt_kick;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdata;
   logic        pready, pslverr, rerr, cpu_stop, cpu_reset, exc_enable;
   logic        guard_out_ch1, guard_out_ch2, conv_strobe_ch1;
   logic        conv_strobe_ch2;
   logic [5:0]  exc_freq_code, offset_comp_ch1, offset_comp_ch2;
   logic [1:0]  range_select_ch1, range_select_ch2;
   cafe_res_t   adc_result_ch1, adc_result_ch2, level_ch1, level_ch2;
   int          n_errors, checks, cyc, bad;

   cafe_ctrl #(.CONV_CYC(CC)) u_cafe_ctrl (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .wdt_kick(wdt_kick),
      .adc_result_ch1(adc_result_ch1), .adc_result_ch2(adc_result_ch2),
      .cpu_stop(cpu_stop), .cpu_reset(cpu_reset),
      .exc_enable(exc_enable), .exc_freq_code(exc_freq_code),
      .guard_out_ch1(guard_out_ch1), .guard_out_ch2(guard_out_ch2),
      .conv_strobe_ch1(conv_strobe_ch1), .conv_strobe_ch2(conv_strobe_ch2),
      .range_select_ch1(range_select_ch1),
      .range_select_ch2(range_select_ch2),
      .offset_comp_ch1(offset_comp_ch1), .offset_comp_ch2(offset_comp_ch2));

   cafe_conv_model u_cafe_conv_model (
      .pclk(pclk), .presetn(presetn), .exc_enable(exc_enable),
      .level_ch1(level_ch1), .level_ch2(level_ch2),
      .adc_result_ch1(adc_result_ch1), .adc_result_ch2(adc_result_ch2));

   // free-running clock
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   task automatic tally_and_finish();
      $display("checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : tally_and_finish

   // hang guard, well past the watchdog expiry test
   initial begin
      #900_000;
      n_errors++;
      tally_and_finish();
   end

   task automatic chk(input string nm, input logic [31:0] got, exp);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   // one apb transfer; answer taken at the edge that sees pready
   task automatic xfer(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 50) begin
         n++;
         @(posedge pclk);
      end
      if (n >= 50) n_errors++;
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : xfer

   task automatic rd(input logic [11:0] a, input logic [31:0] m, e,
                     input string nm);
      xfer(1'b0, a, 32'h0000_0000);
      chk(nm, rdata & m, e);
   endtask : rd

   // counts edges until the chosen channel's capture strobe is seen
   task automatic wait_conv(input int ch);
      cyc = 0;
      do begin
         @(posedge pclk);
         cyc++;
      end while ((ch == 1 ? conv_strobe_ch1 : conv_strobe_ch2) !== 1'b1
                 && cyc < 3000);
      if (cyc >= 3000) n_errors++;
   endtask : wait_conv

   // main sequence
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      presetn = 1'b0;
      wdt_kick = 1'b0;
      level_ch1 = 12'hABC;
      level_ch2 = 12'h123;
      n_errors = 0;
      checks = 0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      // reset values
      rd(`CAFE_CTRL_OFF, 32'hFFFF_FFFF, 32'h0000_0000, "ctrl");
      rd(`CAFE_RANGE_OFF, 32'hFFFF_FFFF, 32'h0000_0000, "rng");
      rd(`CAFE_STBY_OFF, 32'hFFFF_FFFF, 32'h0000_0021, "stby");
      // every range code, channels set independently
      for (int k = 0; k < 3; k++) begin
         xfer(1'b1, `CAFE_RANGE_OFF, 32'(k | ((2 - k) << 2)));
         @(posedge pclk);
         chk("rng1", range_select_ch1, 32'(k));
         chk("rng2", range_select_ch2, 32'(2 - k));
      end
      xfer(1'b1, `CAFE_RANGE_OFF, 32'h0000_000F);
      rd(`CAFE_RANGE_OFF, 32'h0000_000F, 32'h0000_0002, "rng3");
      xfer(1'b1, `CAFE_OFFS_OFF, 32'h0000_007F);
      @(posedge pclk);
      chk("offs1", offset_comp_ch1, 32'h0000_003F);
      chk("offs2", offset_comp_ch2, 32'h0000_0001);
      // excitation code, guards and sweep band
      xfer(1'b1, `CAFE_EXC_OFF, 32'h0000_0028);
      rd(`CAFE_EXC_OFF, 32'h0000_0FFF, 32'h0000_0028, "exc");
      chk("fcode", exc_freq_code, 32'h0000_0028);
      chk("exc_en", exc_enable, 32'h0000_0001);
      chk("guard1", guard_out_ch1, 32'h0000_0001);
      chk("guard2", guard_out_ch2, 32'h0000_0001);
      xfer(1'b1, `CAFE_EXC_OFF, 32'h0000_0090);
      bad = 0;
      cyc = 0;
      repeat (60) begin
         @(posedge pclk);
         if (exc_freq_code < 6'h10 || exc_freq_code > 6'h12) bad++;
         if (exc_freq_code == 6'h12) cyc++;
      end
      chk("sweep", 32'(bad), 32'h0000_0000);
      chk("sweep_top", 32'(cyc), 32'h0000_0014);
      // free-running conversions, data ready and overwrite
      wait_conv(1);
      wait_conv(1);
      chk("period", 32'(cyc >= CC && cyc <= CC + 1), 32'h1);
      rd(`CAFE_RES1_OFF, 32'h0000_0FFF, 32'h0000_0ABC, "res1");
      wait_conv(2);
      rd(`CAFE_STAT_OFF, 32'h0000_0002, 32'h0000_0002, "dr2");
      rd(`CAFE_RES2_OFF, 32'h0000_0FFF, 32'h0000_0123, "res2");
      rd(`CAFE_STAT_OFF, 32'h0000_0002, 32'h0000_0000, "dr2c");
      level_ch1 <= 12'h777;
      wait_conv(1);
      wait_conv(1);
      rd(`CAFE_RES1_OFF, 32'h0000_0FFF, 32'h0000_0777, "ovw");
      // refused accesses
      xfer(1'b1, `CAFE_RES1_OFF, 32'h0000_0111);
      chk("ro_err", rerr, 32'h1);
      rd(`CAFE_RES1_OFF, 32'h0000_0FFF, 32'h0000_0777, "ro");
      chk("ok_err", rerr, 32'h0);
      xfer(1'b0, 12'hFFC, 32'h0000_0000);
      chk("unmap", rerr, 32'h1);
      // both channels down, then standby entry order
      xfer(1'b1, `CAFE_PWR_OFF, 32'h0000_0003);
      repeat (2) @(posedge pclk);
      chk("pd_exc", exc_enable, 32'h0);
      chk("pd_grd", guard_out_ch1, 32'h0);
      chk("pd_cpu", cpu_stop, 32'h0);
      rd(`CAFE_OFFS_OFF, 32'h0000_0FFF, 32'h0000_007F, "pd_keep");
      xfer(1'b1, `CAFE_STBY_OFF, 32'h0000_0042);
      xfer(1'b1, `CAFE_PWR_OFF, 32'h0000_0000);
      level_ch1 <= 12'h05F;
      xfer(1'b1, `CAFE_THR_OFF, 32'h0010_0003);
      xfer(1'b1, `CAFE_WAKE_OFF, 32'h0000_0007);
      xfer(1'b1, `CAFE_CTRL_OFF, 32'h0000_0004);
      @(posedge pclk);
      chk("stop", cpu_stop, 32'h1);
      repeat (2) wait_conv(1);
      wait_conv(1);
      chk("sb1", 32'(cyc >= 2 * CC && cyc <= 2 * CC + 1), 32'h1);
      repeat (2) wait_conv(2);
      chk("sb2", 32'(cyc >= 4 * CC && cyc <= 4 * CC + 1), 32'h1);
      chk("stop2", cpu_stop, 32'h1);
      rd(`CAFE_STAT_OFF, 32'h0000_000C, 32'h0000_0000, "and");
      // switching to or lets the absolute crossing alone wake
      xfer(1'b1, `CAFE_WAKE_OFF, 32'h0000_0006);
      cyc = 0;
      while (cpu_stop !== 1'b0 && cyc < 200) begin
         @(posedge pclk);
         cyc++;
      end
      chk("wake", cpu_stop, 32'h0);
      rd(`CAFE_STAT_OFF, 32'h0000_0004, 32'h0000_0004, "wk1");
      rd(`CAFE_CTRL_OFF, 32'h0000_0004, 32'h0000_0000, "sbclr");
      // single conversion mode
      xfer(1'b1, `CAFE_CTRL_OFF, 32'h0000_0001);
      repeat (50) @(posedge pclk);
      xfer(1'b0, `CAFE_RES1_OFF, 32'h0000_0000);
      repeat (50) @(posedge pclk);
      chk("sc_pwr", exc_enable, 32'h0);
      rd(`CAFE_STAT_OFF, 32'h0000_0001, 32'h0000_0000, "sc_idle");
      level_ch1 <= 12'h456;
      xfer(1'b1, `CAFE_CTRL_OFF, 32'h0000_0003);
      for (int k = 0; k < 20; k++) begin
         xfer(1'b0, `CAFE_CTRL_OFF, 32'h0000_0000);
         if (rdata[1] === 1'b0) break;
      end
      chk("sct_clr", rdata & 32'h2, 32'h0);
      rd(`CAFE_RES1_OFF, 32'h0000_0FFF, 32'h0000_0456, "sc_res");
      // watchdog expiry after a kick
      wdt_kick <= 1'b1;
      @(posedge pclk);
      wdt_kick <= 1'b0;
      cyc = 0;
      while (cpu_reset !== 1'b1 && cyc < 70000) begin
         @(posedge pclk);
         cyc++;
      end
      chk("wdt", 32'(cyc >= 65534 && cyc <= 65538), 32'h1);
      tally_and_finish();
   end
endmodule : capacitive_afe_conversion_control_tb_top
